// ---- verilog/sdm_match_stop.sv ----
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module sdm_match_stop
  import sdm_pkg::*;
#(
  parameter int FRAME_BITS = 16
)(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output      logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output      logic        bvalid,
  input  wire logic        bready,
  output      logic [1:0]  bresp,
  input  wire logic        arvalid,
  output      logic        arready,
  input  wire logic [7:0]  araddr,
  output      logic        rvalid,
  input  wire logic        rready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        serialClk,
  output      logic        serialOut,
  input  wire logic        serialIn,
  output      logic        chipSelect_n,
  output      logic        irq
);

  // ===========================================================
  // Registers
  sdm_cfg_s               cfg_q;
  logic [FRAME_BITS-1:0]  polarity_q, mask_q, txData_q, rxData_q, shift_q;
  logic [1:0]             status_q, irqMask_q;
  sdm_state_e             state_q;
  logic [15:0]            divCnt_q;
  logic [7:0]             bitCnt_q;
  logic                   sIn1_q, sIn2_q;
  logic                   startReq_q;
  logic                   awHeld_q, wHeld_q;
  logic [7:0]             awAddr_q;
  logic [31:0]            wData_q;
  logic [3:0]             wStrb_q;
  logic                   frameDone, matchHit, statusRead, doWrite, tick;

  function automatic logic [FRAME_BITS-1:0] sdm_strobe(
    input logic [FRAME_BITS-1:0] oldVal,
    input logic [31:0]           newVal,
    input logic [3:0]            strb
  );
    logic [31:0] w;
    w = {{(32-FRAME_BITS){1'b0}}, oldVal};
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        w[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return w[FRAME_BITS-1:0];
  endfunction : sdm_strobe
  function automatic logic sdm_match(
    input logic [FRAME_BITS-1:0] rx,
    input logic [FRAME_BITS-1:0] pol,
    input logic [FRAME_BITS-1:0] msk
  );
    return (((rx ^ pol) & ~msk) == '0);
  endfunction : sdm_match

  // ===========================================================
  // AXI write path
  assign awready = ~awHeld_q;
  assign wready  = ~wHeld_q;
  assign doWrite = awHeld_q & wHeld_q & ~bvalid;
  assign bresp   = RESP_OKAY;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= ZERO_WORD;
      wStrb_q  <= 4'h0;
      bvalid   <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        bvalid   <= 1'b1;
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // ===========================================================
  // Config registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q      <= '0;
      polarity_q <= '0;
      mask_q     <= '0;
      txData_q   <= '0;
      irqMask_q  <= 2'h0;
      startReq_q <= 1'b0;
    end
    else
    begin
      startReq_q <= 1'b0;
      if (doWrite)
      begin
        unique case (awAddr_q)
          MODULE_CONFIG_OFS:
          begin
            if (wStrb_q[0])
            begin
              cfg_q.masterSelect       <= wData_q[MASTER_SELECT_POS];
              cfg_q.framingConfigField <= wData_q[FRAMING_FIELD_HI:FRAMING_FIELD_LO];
            end
          end
          DESERIAL_CFG0_OFS:
          begin
            if (wStrb_q[0])
            begin
              cfg_q.matchStopBit <= wData_q[MATCH_STOP_POS];
              startReq_q         <= wData_q[START_POS];
            end
          end
          MATCH_POLARITY_OFS: polarity_q <= sdm_strobe(polarity_q, wData_q, wStrb_q);
          MATCH_MASK_OFS:     mask_q     <= sdm_strobe(mask_q, wData_q, wStrb_q);
          IRQ_MASK_OFS:       irqMask_q  <= wStrb_q[0] ? wData_q[1:0] : irqMask_q;
          TX_DATA_OFS:        txData_q   <= sdm_strobe(txData_q, wData_q, wStrb_q);
          default:            ;
        endcase
      end
    end
  end

  // ===========================================================
  // AXI read path
  assign arready    = ~rvalid;
  assign rresp      = RESP_OKAY;
  assign statusRead = arvalid && arready && (araddr == MODULE_STATUS_OFS);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid <= 1'b0;
      rdata  <= ZERO_WORD;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      unique case (araddr)
        MODULE_CONFIG_OFS:  rdata <= 32'({cfg_q.framingConfigField, cfg_q.masterSelect});
        DESERIAL_CFG0_OFS:  rdata <= 32'(cfg_q.matchStopBit);
        MATCH_POLARITY_OFS: rdata <= 32'(polarity_q);
        MATCH_MASK_OFS:     rdata <= 32'(mask_q);
        MODULE_STATUS_OFS:
          rdata <= 32'({state_q == SDM_SHIFT, state_q == SDM_STOPPED, status_q});
        IRQ_MASK_OFS:       rdata <= 32'(irqMask_q);
        TX_DATA_OFS:        rdata <= 32'(txData_q);
        RX_DATA_OFS:        rdata <= 32'(rxData_q);
        default:            rdata <= ZERO_WORD;
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // ===========================================================
  // Serial engine
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {sIn2_q, sIn1_q} <= 2'h0;
    end
    else
    begin
      {sIn2_q, sIn1_q} <= {sIn1_q, serialIn};
    end
  end
  assign tick = (divCnt_q == 16'(SCK_HALF_CYC - 1));
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divCnt_q <= 16'h0000;
    end
    else if (state_q != SDM_SHIFT || tick)
    begin
      divCnt_q <= 16'h0000;
    end
    else
    begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  assign frameDone = (state_q == SDM_SHIFT) && tick && serialClk
                     && (bitCnt_q == 8'(FRAME_BITS - 1));
  assign matchHit  = frameDone
                     && sdm_match({shift_q[FRAME_BITS-2:0], sIn2_q}, polarity_q, mask_q);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q   <= SDM_IDLE;
      serialClk <= 1'b0;
      bitCnt_q  <= 8'h00;
      shift_q   <= '0;
      rxData_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        SDM_IDLE:
        begin
          // Master role in deserial framing only
          if (startReq_q && cfg_q.masterSelect
              && cfg_q.framingConfigField == FRAMING_DESERIAL)
          begin
            state_q  <= SDM_SHIFT;
            shift_q  <= txData_q;
            bitCnt_q <= 8'h00;
          end
        end
        SDM_SHIFT:
        begin
          if (tick)
          begin
            serialClk <= ~serialClk;
            if (serialClk)
            begin
              shift_q  <= {shift_q[FRAME_BITS-2:0], sIn2_q};
              bitCnt_q <= bitCnt_q + 8'h01;
              if (frameDone)
              begin
                rxData_q <= {shift_q[FRAME_BITS-2:0], sIn2_q};
                // Stopped state is sticky: only reset leaves it
                state_q  <= (matchHit && cfg_q.matchStopBit) ? SDM_STOPPED
                                                             : SDM_IDLE;
              end
            end
          end
        end
        SDM_STOPPED: state_q <= SDM_STOPPED;
      endcase
    end
  end

  assign serialOut    = shift_q[FRAME_BITS-1];
  assign chipSelect_n = (state_q != SDM_SHIFT);

  // ===========================================================
  // Status and interrupt; set wins over read-clear
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q <= 2'h0;
    end
    else
    begin
      status_q <= (statusRead ? 2'h0 : status_q) | {frameDone, matchHit};
    end
  end

  assign irq = |(status_q & irqMask_q);

endmodule : sdm_match_stop

// ---- verilog/sdm_pkg.sv ----
// Notes on behaviour
// - Master role when master select bit set
// - Deserial framing when config field is 01
// - Compare received frame against polarity and mask
// - Match-stop bit set: stop after a matching frame
// - Match sets flag and raises interrupt
// - Stopped transfers never restart after flag clear
package sdm_pkg;

  // ===========================================================
  // Register byte offsets
  localparam logic [7:0] MODULE_CONFIG_OFS  = 8'h00;
  localparam logic [7:0] DESERIAL_CFG0_OFS  = 8'h04;
  localparam logic [7:0] MATCH_POLARITY_OFS = 8'h08;
  localparam logic [7:0] MATCH_MASK_OFS     = 8'h0C;
  localparam logic [7:0] MODULE_STATUS_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h14;
  localparam logic [7:0] TX_DATA_OFS        = 8'h18;
  localparam logic [7:0] RX_DATA_OFS        = 8'h1C;

  // ===========================================================
  // Field positions
  localparam int MASTER_SELECT_POS  = 0;
  localparam int FRAMING_FIELD_LO   = 1;
  localparam int FRAMING_FIELD_HI   = 2;
  localparam int MATCH_STOP_POS     = 0;
  localparam int START_POS          = 1;
  localparam int MATCH_FLAG_POS     = 0;
  localparam int DONE_FLAG_POS      = 1;
  localparam int STOPPED_POS        = 2;
  localparam int BUSY_POS           = 3;

  localparam logic [1:0] FRAMING_DESERIAL = 2'h1;
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
  localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

  // ===========================================================
  // Timing: serial clock period
  localparam int SCK_PERIOD_NS = 1000;
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCK_HALF_CYC  = SCK_PERIOD_NS / SYS_PERIOD_NS / 2;

  typedef struct packed {
    logic        masterSelect;
    logic [1:0]  framingConfigField;
    logic        matchStopBit;
  } sdm_cfg_s;

  typedef enum {SDM_IDLE, SDM_SHIFT, SDM_STOPPED} sdm_state_e;

endpackage : sdm_pkg

// ---- bench/sdm_match_stop_monitor.sv ----
`timescale 1ns/1ps
module sdm_match_stop_monitor
  import sdm_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        serialClk,
  input wire logic        chipSelect_n,
  input wire logic        irq
);
  // ==========================================
  // Port relations
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_clk_idle_low: assert property (chipSelect_n |-> !serialClk)
    else $error("serial clock moves outside a frame");
  a_start_after_write: assert property ($fell(chipSelect_n) |-> bvalid || $past(bvalid))
    else $error("frame began without a register write");
  a_frame_not_short: assert property ($fell(chipSelect_n) |=> !chipSelect_n [*8])
    else $error("frame ended too early");
  a_slow_clock: assert property ($rose(serialClk) |=> serialClk [*8])
    else $error("serial clock high phase too short");
  a_irq_frame_end: assert property ($rose(irq) |-> chipSelect_n)
    else $error("interrupt rose during a frame");
  a_irq_clear_cause: assert property ($fell(irq) |-> rvalid || bvalid || $past(bvalid))
    else $error("interrupt dropped without an access");
  a_write_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write response not held");
  a_bresp_okay: assert property (bvalid |-> bresp == RESP_OKAY)
    else $error("write response not okay");
  a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_refused: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  c_irq: cover property ($rose(irq));
  c_frame: cover property ($fell(chipSelect_n));
  c_read: cover property (rvalid && rready);
endmodule : sdm_match_stop_monitor

bind sdm_match_stop sdm_match_stop_monitor mon (.*);

// ---- bench/sdm_remote_model.sv ----
`timescale 1ns/1ps
module sdm_remote_model
#(
  parameter logic [15:0] REPLY = 16'hA5C3
)(
  input  wire logic serialClk,
  input  wire logic serialOut,
  input  wire logic chipSelect_n,
  output      logic serialIn
);
  // ==========================================
  // Remote peripheral
  logic [15:0] txSeen;
  int          bitCnt;
  initial serialIn = 1'b0;
  always @(negedge chipSelect_n)
  begin
    bitCnt = 0;
    serialIn = REPLY[15];
  end
  always @(negedge serialClk)
  begin
    bitCnt++;
    serialIn = (bitCnt < 16) ? REPLY[15 - bitCnt] : serialIn;
  end
  // Released line shows no held value
  always @(posedge chipSelect_n) serialIn = ~serialIn;
  // Mid-bit capture, clear of the launch edge
  always @(posedge serialClk) txSeen = {txSeen[14:0], serialOut};
endmodule : sdm_remote_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import sdm_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n, awvalid, wvalid, bready, arvalid, rready, serialIn;
  logic        awready, wready, bvalid, arready, rvalid, serialClk, serialOut, chipSelect_n, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          badCount, totalChecks, cycles;
  sdm_match_stop uut (.*);
  sdm_remote_model peer (.serialClk, .serialOut, .chipSelect_n, .serialIn);
  always #5 clk_sys = ~clk_sys;
  // ==========================================
  // Shared tasks
  task stopTest();
    $display("checks %0d errors %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stopTest
  // Hang guard: frames take about 1600 cycles each
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      badCount++;
      stopTest();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task axw(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw;
    {ta, tw} = 2'b00;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    do
    begin
      @(posedge clk_sys);
      ta |= awready;
      tw |= wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end while (!(ta && tw));
    do @(posedge clk_sys); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axr
  task wcs(input logic v);
    for (int n = 0; n < 4000 && chipSelect_n !== v; n++) @(posedge clk_sys);
  endtask : wcs
  task frame(input logic [31:0] cfg0);
    axw(DESERIAL_CFG0_OFS, cfg0);
    wcs(1'b0);
    wcs(1'b1);
  endtask : frame
  // ==========================================
  // Scenarios
  task tReset();
    chk(irq, 32'h0);
    chk(chipSelect_n, 32'h1);
    axr(MODULE_STATUS_OFS, rd);
    chk(rd, ZERO_WORD);
    axw(8'h20, 32'hFFFF_FFFF);
    axr(8'h20, rd);
    chk(rd, ZERO_WORD);
    chk(rresp, 32'(RESP_OKAY));
  endtask : tReset
  // Master only, then framing only: neither may shift
  task tRoles();
    for (int i = 1; i < 3; i++)
    begin
      axw(MODULE_CONFIG_OFS, 32'(i));
      axw(DESERIAL_CFG0_OFS, 32'h0000_0002);
      wcs(1'b0);
      chk(chipSelect_n, 32'h1);
    end
  endtask : tRoles
  task tNoMatch();
    axw(MODULE_CONFIG_OFS, 32'h0000_0003);
    axw(TX_DATA_OFS, 32'h0000_3C5A);
    axw(MATCH_POLARITY_OFS, 32'h0000_A5C2);
    axw(MATCH_MASK_OFS, ZERO_WORD);
    axw(IRQ_MASK_OFS, 32'h0000_0001);
    frame(32'h0000_0002);
    chk(peer.txSeen, 32'h0000_3C5A);
    axr(RX_DATA_OFS, rd);
    chk(rd, 32'h0000_A5C3);
    chk(irq, 32'h0);
    axr(MODULE_STATUS_OFS, rd);
    chk(rd, 32'h0000_0002);
  endtask : tNoMatch
  task tMask();
    axw(MATCH_MASK_OFS, 32'h0000_0001);
    axw(IRQ_MASK_OFS, ZERO_WORD);
    frame(32'h0000_0002);
    chk(irq, 32'h0);
    axw(IRQ_MASK_OFS, 32'h0000_0001);
    chk(irq, 32'h1);
    axr(MODULE_STATUS_OFS, rd);
    chk(rd, 32'h0000_0003);
    @(posedge clk_sys);
    chk(irq, 32'h0);
  endtask : tMask
  task tStop();
    axw(MATCH_POLARITY_OFS, 32'h0000_A5C3);
    axw(MATCH_MASK_OFS, ZERO_WORD);
    frame(32'h0000_0003);
    axr(MODULE_STATUS_OFS, rd);
    chk(rd, 32'h0000_0007);
    axw(DESERIAL_CFG0_OFS, 32'h0000_0002);
    wcs(1'b0);
    chk(chipSelect_n, 32'h1);
    axr(MODULE_STATUS_OFS, rd);
    chk(rd, 32'h0000_0004);
  endtask : tStop
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    reset_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    tReset();
    tRoles();
    tNoMatch();
    tMask();
    tStop();
    stopTest();
  end
endmodule : tb_top
